// ---- cdd_pkg.sv ----
// package for the clock divider distribution control block
// assumes byte-wide registers reached by a plain address/strobe port
package cdd_pkg;
	localparam logic [9:0] ADDR_CH0_COUNTS = 10'h190;
	localparam logic [9:0] ADDR_CH0_CTRL = 10'h191;
	localparam logic [9:0] ADDR_CH1_COUNTS = 10'h193;
	localparam logic [9:0] ADDR_CH1_CTRL = 10'h194;
	localparam logic [9:0] ADDR_CH2_COUNTS = 10'h196;
	localparam logic [9:0] ADDR_CH2_CTRL = 10'h197;
	localparam logic [9:0] ADDR_CH3_S1_COUNTS = 10'h199;
	localparam logic [9:0] ADDR_CH3_PHASE = 10'h19a;
	localparam logic [9:0] ADDR_CH3_S2_COUNTS = 10'h19b;
	localparam logic [9:0] ADDR_CH3_CTRL = 10'h19c;
	localparam logic [9:0] ADDR_CH4_S1_COUNTS = 10'h19e;
	localparam logic [9:0] ADDR_CH4_PHASE = 10'h19f;
	localparam logic [9:0] ADDR_CH4_S2_COUNTS = 10'h1a0;
	localparam logic [9:0] ADDR_CH4_CTRL = 10'h1a1;
	localparam logic [9:0] ADDR_SRC_RATIO = 10'h1e0;
	localparam logic [9:0] ADDR_INPUT_SEL = 10'h1e1;
	localparam logic [9:0] ADDR_SYSTEM = 10'h230;
	localparam logic [9:0] ADDR_TRANSFER = 10'h232;
	// single-stage control fields
	localparam int SS_BYPASS = 7;
	localparam int SS_NOSYNC = 6;
	localparam int SS_FORCE = 5;
	localparam int SS_START = 4;
	// dual-stage control fields
	localparam int DS_BYP2 = 5;
	localparam int DS_BYP1 = 4;
	localparam int DS_NOSYNC = 3;
	localparam int DS_FORCE = 2;
	localparam int DS_START2 = 1;
	localparam int DS_START1 = 0;
	// source, system and transfer fields
	localparam int IS_PD_INPUT = 4;
	localparam int IS_PD_IFACE = 3;
	localparam int IS_PD_VCO = 2;
	localparam int IS_SEL_VCO = 1;
	localparam int IS_BYP_DIV = 0;
	localparam int SY_PD_SYNC = 2;
	localparam int SY_PD_DIST = 1;
	localparam int SY_SOFT_SYNC = 0;
	localparam int TR_UPDATE = 0;
	// reset values, static source threshold and divider offset
	localparam logic [7:0] RST_CH0_CTRL = 8'h80;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_SRC_RATIO = 8'h02;
	localparam logic [2:0] SRC_STATIC_MIN = 3'h5;
	localparam logic [3:0] DIV_EXTRA = 4'h2;
endpackage

// ---- cdd_top.sv ----
// clock divider distribution control: shadow/active registers and dividers
// assumes clk_in_ext and clk_in_vco are clock-rate enables sampled on clk
`timescale 1ns/100ps

// one divider stage with duty correction, phase offset and start level
module cdd_stage (
	// clock
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// control
	input wire logic tick,
	input wire logic [7:0] counts,
	input wire logic [3:0] phase,
	input wire logic start_high,
	input wire logic bypass,
	input wire logic restart,
	input wire logic in_level,
	// output
	output logic tick_out,
	output logic level
);
	logic [5:0] cnt;
	logic [4:0] ratio;
	logic [4:0] half;
	logic [3:0] delay;
	assign ratio = 5'(counts[7:4]) + 5'(counts[3:0]) + 5'h02; // [RQ1]
	// odd ratios give the extra input cycle to the second half
	assign half = ratio >> 1;
	// duty is half the ratio whatever the split, as corrected [RQ2]
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt <= 6'h00;
			delay <= 4'h0;
			level <= 1'b0;
		end else if (ce) begin
			if (restart) begin
				cnt <= 6'h00;
				delay <= phase; // [RQ7] [RQ21]
				level <= start_high; // [RQ6]
			end else if (tick) begin
				if (delay != 4'h0) begin
					delay <= delay - 4'h1;
				end else if (cnt + 6'h01 >= 6'(ratio)) begin
					cnt <= 6'h00;
					level <= ~level;
				end else begin
					if (cnt + 6'h01 == 6'(half)) begin
						level <= ~level;
					end
					cnt <= cnt + 6'h01;
				end
			end
		end
	end
	// an unbypassed stage ticks its successor at count zero, once per output period (every input tick when the ratio wraps to zero); a bypassed one passes every tick
	assign tick_out = bypass ? tick : (tick && delay == 4'h0 && cnt == 6'h00); // [RQ3] [RQ8]
	logic unused;
	assign unused = in_level;
endmodule

////////////////////////////////////////////////////////////////////////////////

// Contract
// RQ1 - stage divides by low plus high plus two; both counts at 15 wrap the 5-bit ratio to zero and the stage divides by two
// RQ2 - duty correction always on for outputs
// RQ3 - bypass powers down, passes input; ch0 bypassed
// RQ4 - sync-ignore bit clear obeys chip sync
// RQ5 - force bit sets level when sync ignored
// RQ6 - start bit picks initial output level
// RQ7 - four-bit phase offset delays divided output
// RQ8 - dual-stage bypass bits per stage, default off
// RQ9 - dual-stage channel shares nosync and force
// RQ10 - dual-stage start levels per stage
// RQ11 - source divider 2..6, higher codes static
// RQ12 - input power-down stops buffer, divider, tree
// RQ13 - source select picks external clock or vco
// RQ14 - bit zero bypasses the source divider
// RQ15 - interface and vco power-down bits
// RQ16 - sync power-down disables sync circuitry
// RQ17 - distribution power-down turns buffers off
// RQ18 - soft sync holds, falling edge syncs
// RQ19 - update bit copies buffers, self clears
// RQ20 - writes land in buffers until transfer
// RQ21 - sync restarts dividers with start, offset
module cdd_top (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// register port
	input wire logic [9:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// clock sources and sync pin
	input wire logic clk_in_ext,
	input wire logic clk_in_vco,
	input wire logic sync_pin_n,
	// outputs
	output logic [4:0] chan_out,
	output logic [4:0] chan_enable,
	output logic input_powered,
	output logic vco_powered,
	output logic iface_powered
);
	import cdd_pkg::*;
	localparam int NREG = 18;
	localparam logic [9:0] ADDRS [NREG] = '{ADDR_CH0_COUNTS, ADDR_CH0_CTRL, ADDR_CH1_COUNTS,
		ADDR_CH1_CTRL, ADDR_CH2_COUNTS, ADDR_CH2_CTRL, ADDR_CH3_S1_COUNTS, ADDR_CH3_PHASE,
		ADDR_CH3_S2_COUNTS, ADDR_CH3_CTRL, ADDR_CH4_S1_COUNTS, ADDR_CH4_PHASE, ADDR_CH4_S2_COUNTS,
		ADDR_CH4_CTRL, ADDR_SRC_RATIO, ADDR_INPUT_SEL, ADDR_SYSTEM, ADDR_TRANSFER};
	localparam logic [7:0] RSTV [NREG] = '{RST_ZERO, RST_CH0_CTRL, RST_ZERO, RST_ZERO, RST_ZERO,
		RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
		RST_SRC_RATIO, RST_ZERO, RST_ZERO, RST_ZERO};
	localparam int I_SRC = 14;
	localparam int I_INP = 15;
	localparam int I_SYS = 16;
	localparam int I_TRF = 17;

	logic [7:0] shadow [NREG];
	logic [7:0] active [NREG];
	logic transfer;

	////////////////////////////////////////////////////////////////////////////
	// register port: writes land in shadow only [RQ20]
	assign transfer = ce && wr && addr == ADDR_TRANSFER && wdata[TR_UPDATE]; // [RQ19]
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < NREG; i++) begin
				shadow[i] <= RSTV[i];
			end
		end else if (ce && wr) begin
			for (int i = 0; i < NREG; i++) begin
				if (addr == ADDRS[i] && i != I_TRF) begin
					shadow[i] <= wdata;
				end
			end
		end
	end
	// copy on the edge after the strobe; the strobe bit never stores [RQ19]
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < NREG; i++) begin
				active[i] <= RSTV[i];
			end
		end else if (ce && transfer) begin
			for (int i = 0; i < I_TRF; i++) begin
				active[i] <= shadow[i];
			end
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= 8'h00;
		end else if (ce) begin
			rdata <= 8'h00;
			if (rd) begin
				for (int i = 0; i < I_TRF; i++) begin
					if (addr == ADDRS[i]) begin
						rdata <= shadow[i];
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// source pins pass two flops before use
	logic [2:0] meta;
	logic [2:0] syncd;
	always_ff @(posedge clk) begin
		if (rst) begin
			// reset to the idle pin levels, so release shows no false sync
			meta <= 3'h4;
			syncd <= 3'h4;
		end else if (ce) begin
			meta <= {sync_pin_n, clk_in_vco, clk_in_ext};
			syncd <= meta;
		end
	end

	logic pd_input;
	logic sel_vco;
	logic src_tick;
	logic src_raw;
	assign pd_input = active[I_INP][IS_PD_INPUT]; // [RQ12]
	// illegal combination: vco selected with bypass, treated as divider in use [RQ13] [RQ14]
	assign sel_vco = active[I_INP][IS_SEL_VCO];
	assign src_raw = sel_vco ? (syncd[1] & ~active[I_INP][IS_PD_VCO]) : (syncd[0] & ~active[I_INP][IS_PD_VCO]); // [RQ15]
	assign input_powered = ~pd_input;
	assign vco_powered = ~active[I_INP][IS_PD_VCO];
	assign iface_powered = ~active[I_INP][IS_PD_IFACE]; // [RQ15]

	logic [2:0] src_cnt;
	logic [2:0] src_ratio;
	logic src_div_tick;
	always_comb begin
		case (active[I_SRC][2:0]) // [RQ11]
			3'h0: src_ratio = 3'h2;
			3'h1: src_ratio = 3'h3;
			3'h2: src_ratio = 3'h4;
			3'h3: src_ratio = 3'h5;
			3'h4: src_ratio = 3'h6;
			default: src_ratio = 3'h0;
		endcase
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			src_cnt <= 3'h0;
		end else if (ce && src_raw && !pd_input) begin
			src_cnt <= (src_cnt + 3'h1 >= src_ratio) ? 3'h0 : src_cnt + 3'h1;
		end
	end
	assign src_div_tick = src_raw && src_cnt == 3'h0 && active[I_SRC][2:0] < SRC_STATIC_MIN; // [RQ11]
	assign src_tick = !pd_input && ((active[I_INP][IS_BYP_DIV] && !sel_vco) ? src_raw : src_div_tick); // [RQ12] [RQ14]

	////////////////////////////////////////////////////////////////////////////
	// sync: pin low or soft bit high holds, release triggers [RQ18]
	logic hold;
	logic hold_d;
	logic sync_evt;
	assign hold = !active[I_SYS][SY_PD_SYNC] && (!syncd[2] || active[I_SYS][SY_SOFT_SYNC]); // [RQ16]
	always_ff @(posedge clk) begin
		if (rst) begin
			hold_d <= 1'b0;
		end else if (ce) begin
			hold_d <= hold;
		end
	end
	// hold_d resets low: a sync held through reset syncs on release
	assign sync_evt = hold_d && !hold; // [RQ18]

	////////////////////////////////////////////////////////////////////////////
	// channels
	logic [4:0] nosync;
	logic [4:0] force_hi;
	logic [4:0] div_level;
	logic [1:0] mid_tick;
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gen_single
			logic [7:0] ctl;
			logic lvl;
			assign ctl = active[2 * g + 1];
			assign nosync[g] = ctl[SS_NOSYNC]; // [RQ4]
			assign force_hi[g] = ctl[SS_FORCE];
			cdd_stage u_stage (.clk(clk), .rst(rst), .ce(ce), .tick(src_tick), .counts(active[2 * g]),
				.phase(ctl[3:0]), .start_high(ctl[SS_START]), .bypass(ctl[SS_BYPASS]),
				.restart((sync_evt || hold) && !ctl[SS_NOSYNC]), .in_level(1'b0), .tick_out(), .level(lvl));
			assign div_level[g] = ctl[SS_BYPASS] ? src_raw : lvl; // [RQ3]
		end
		for (g = 0; g < 2; g++) begin : gen_dual
			logic [7:0] ctl;
			logic [7:0] ph;
			logic l1;
			logic l2;
			logic rs;
			assign ctl = active[6 + 4 * g + 3];
			assign ph = active[6 + 4 * g + 1];
			assign nosync[3 + g] = ctl[DS_NOSYNC]; // [RQ9]
			assign force_hi[3 + g] = ctl[DS_FORCE];
			assign rs = (sync_evt || hold) && !ctl[DS_NOSYNC];
			cdd_stage u_s1 (.clk(clk), .rst(rst), .ce(ce), .tick(src_tick), .counts(active[6 + 4 * g]),
				.phase(ph[3:0]), .start_high(ctl[DS_START1]), .bypass(ctl[DS_BYP1]), .restart(rs),
				.in_level(1'b0), .tick_out(mid_tick[g]), .level(l1)); // [RQ8] [RQ10]
			cdd_stage u_s2 (.clk(clk), .rst(rst), .ce(ce), .tick(mid_tick[g]), .counts(active[6 + 4 * g + 2]),
				.phase(ph[7:4]), .start_high(ctl[DS_START2]), .bypass(ctl[DS_BYP2]), .restart(rs),
				.in_level(l1), .tick_out(), .level(l2)); // [RQ8] [RQ10]
			assign div_level[3 + g] = ctl[DS_BYP2] ? (ctl[DS_BYP1] ? src_raw : l1) : l2;
		end
	endgenerate

	// forced level needs nosync set; held channels sit low [RQ5] [RQ18]
	always_ff @(posedge clk) begin
		if (rst) begin
			chan_out <= 5'h00;
		end else if (ce) begin
			for (int i = 0; i < 5; i++) begin
				if (active[I_SYS][SY_PD_DIST] || pd_input) begin
					chan_out[i] <= 1'b0; // [RQ17]
				end else if (nosync[i]) begin
					chan_out[i] <= force_hi[i] ? 1'b1 : div_level[i]; // [RQ5]
				end else if (hold) begin
					chan_out[i] <= 1'b0;
				end else begin
					chan_out[i] <= div_level[i];
				end
			end
		end
	end
	assign chan_enable = {5{~active[I_SYS][SY_PD_DIST]}}; // [RQ17]

	////////////////////////////////////////////////////////////////////////////
	// register path
	a_transfer_copy: assert property (@(posedge clk) disable iff (rst) // [RQ19]
		(ce && wr && addr == ADDR_TRANSFER && wdata[TR_UPDATE]) |=> active[I_SYS] == $past(shadow[I_SYS]))
		else $error("transfer missed");
	a_shadow_only: assert property (@(posedge clk) disable iff (rst) // [RQ20]
		(ce && !transfer) |=> $stable(active[I_INP]))
		else $error("active changed without transfer");
	a_shadow_write: assert property (@(posedge clk) disable iff (rst) // [RQ20]
		(ce && wr && addr == ADDR_SYSTEM) |=> shadow[I_SYS] == $past(wdata))
		else $error("buffer write lost");
	a_read_zero: assert property (@(posedge clk) disable iff (rst) // [RQ19]
		(ce && rd && addr == ADDR_TRANSFER) |=> rdata == 8'h00)
		else $error("update strobe read back");
	// divided outputs, sync and source ticks
	a_dist_off: assert property (@(posedge clk) disable iff (rst) // [RQ17]
		(ce && active[I_SYS][SY_PD_DIST]) |=> chan_out == 5'h00)
		else $error("outputs not off");
	a_input_off: assert property (@(posedge clk) disable iff (rst) // [RQ12]
		(ce && pd_input) |=> chan_out == 5'h00)
		else $error("outputs run with input powered down");
	a_force_high: assert property (@(posedge clk) disable iff (rst) // [RQ5]
		(ce && !active[I_SYS][SY_PD_DIST] && !pd_input && active[5][SS_NOSYNC] && active[5][SS_FORCE])
		|=> chan_out[2])
		else $error("force high lost");
	a_bypass_pass: assert property (@(posedge clk) disable iff (rst) // [RQ3]
		(ce && active[1][SS_BYPASS] && !active[1][SS_NOSYNC] && !hold && !pd_input && !active[I_SYS][SY_PD_DIST])
		|=> chan_out[0] == $past(src_raw))
		else $error("bypassed channel not passing input");
	a_hold_low: assert property (@(posedge clk) disable iff (rst) // [RQ18]
		(ce && hold && !nosync[1]) |=> !chan_out[1])
		else $error("held channel not low");
	a_dual_hold: assert property (@(posedge clk) disable iff (rst) // [RQ9]
		(ce && hold && !nosync[3]) |=> !chan_out[3])
		else $error("held dual channel not low");
	a_sync_restart: assert property (@(posedge clk) disable iff (rst) // [RQ21]
		(ce && sync_evt && !nosync[1] && !active[3][SS_BYPASS] && !pd_input && !active[I_SYS][SY_PD_DIST])
		|-> ##2 chan_out[1] == $past(active[3][SS_START], 2))
		else $error("sync restart level wrong");
	a_sync_edge: assert property (@(posedge clk) disable iff (rst) // [RQ18]
		sync_evt |-> $past(hold) && !hold)
		else $error("bad sync edge");
	a_sync_pd: assert property (@(posedge clk) disable iff (rst) // [RQ16]
		active[I_SYS][SY_PD_SYNC] |-> !hold)
		else $error("sync not powered down");
	a_static_src: assert property (@(posedge clk) disable iff (rst) // [RQ11]
		(active[I_SRC][2:0] >= SRC_STATIC_MIN && !(active[I_INP][IS_BYP_DIV] && !sel_vco)) |-> !src_tick)
		else $error("static divider ticked");
	a_pd_input: assert property (@(posedge clk) disable iff (rst) // [RQ12]
		pd_input |-> !src_tick)
		else $error("powered-down input ticked");
endmodule

// ---- cdd_host.sv ----
// host model: drives the register port of cdd_top
// assumes a free-running clk; one strobe per call, a cycle between calls
`timescale 1ns/100ps
module cdd_host (
	// clock
	input wire logic clk,
	// register port
	output logic [9:0] addr,
	output logic [7:0] wdata,
	output logic wr,
	output logic rd
);
	import cdd_pkg::*;
	initial begin
		addr = 10'h000;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end
	task automatic write_reg(input logic [9:0] a, input logic [7:0] d);
		// forcing only works with sync ignored, so the host pairs them on the single-stage channel controls
		if ((a == ADDR_CH0_CTRL || a == ADDR_CH1_CTRL || a == ADDR_CH2_CTRL) && d[SS_FORCE])
			d[SS_NOSYNC] = 1'b1;
		// vco as source and divider bypass never together
		if (a == ADDR_INPUT_SEL && d[IS_SEL_VCO])
			d[IS_BYP_DIV] = 1'b0;
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		wdata <= ~d;
	endtask
	task automatic read_reg(input logic [9:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
	endtask
	task automatic update();
		write_reg(ADDR_TRANSFER, 8'h01);
	endtask
endmodule

// ---- cdd_top_bench.sv ----
// bench for cdd_top: registers, buffered update, divider outputs, sync
// assumes sources tick every clk while high; ce held high
`timescale 1ns/100ps
module cdd_top_bench;
	import cdd_pkg::*;
	logic clk, rst, ce, wr, rd, clk_in_ext, clk_in_vco, sync_pin_n, lvl;
	logic rd_seen = 1'b0;
	logic [9:0] addr;
	logic [7:0] wdata, rdata, v;
	logic [4:0] chan_out, chan_enable;
	logic input_powered, vco_powered, iface_powered;
	logic [7:0] exp_q[$];
	logic [9:0] regs[18];
	logic [7:0] rst_val[18], mask[18];
	int n_errors, checks_done, hits;
	int cycles = 0;
	cdd_host i_host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
	cdd_top i_dut (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .clk_in_ext(clk_in_ext), .clk_in_vco(clk_in_vco), .sync_pin_n(sync_pin_n),
		.chan_out(chan_out), .chan_enable(chan_enable), .input_powered(input_powered),
		.vco_powered(vco_powered), .iface_powered(iface_powered));
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		if (n_errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		i_host.read_reg(a);
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask
	// period and high time of one channel, bounded so a dead output cannot hang
	task automatic measure(input int ch, input int d);
		int hi, lo, t;
		t = 0;
		hi = 0;
		lo = 0;
		// whole periods pass first, so counts changed mid-period are not measured
		repeat (3) begin
			while (chan_out[ch] !== 1'b0 && t < 1000) begin
				wait_n(1);
				t++;
			end
			while (chan_out[ch] !== 1'b1 && t < 1000) begin
				wait_n(1);
				t++;
			end
		end
		while (chan_out[ch] === 1'b1 && hi < 300) begin wait_n(1); hi++; end
		while (chan_out[ch] === 1'b0 && lo < 300) begin wait_n(1); lo++; end
		check(16'(hi + lo), 16'(d));
		check(16'(hi), 16'(d / 2));
	endtask
	task automatic count_high(input int ch, input int n);
		hits = 0;
		repeat (n) begin wait_n(1); hits += int'(chan_out[ch] === 1'b1); end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		rd_seen <= rd;
		clk_in_vco <= 1'($urandom);
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			n_errors++;
			results();
		end
	end
	// read data stand only in the cycle after the strobe
	always @(negedge clk)
		if (rd_seen === 1'b1 && exp_q.size() > 0)
			check(rdata, exp_q.pop_front());
	initial begin
		regs = '{ADDR_CH0_COUNTS, ADDR_CH0_CTRL, ADDR_CH1_COUNTS, ADDR_CH1_CTRL, ADDR_CH2_COUNTS,
			ADDR_CH2_CTRL, ADDR_CH3_S1_COUNTS, ADDR_CH3_PHASE, ADDR_CH3_S2_COUNTS, ADDR_CH3_CTRL,
			ADDR_CH4_S1_COUNTS, ADDR_CH4_PHASE, ADDR_CH4_S2_COUNTS, ADDR_CH4_CTRL, ADDR_SRC_RATIO,
			ADDR_INPUT_SEL, ADDR_SYSTEM, ADDR_TRANSFER};
		rst_val = '{default: 8'h00};
		rst_val[1] = RST_CH0_CTRL;
		rst_val[14] = RST_SRC_RATIO;
		mask = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff,
			8'hff, 8'h3f, 8'h07, 8'h1f, 8'h07, 8'h00};
		n_errors = 0;
		checks_done = 0;
		rst = 1'b1;
		ce = 1'b1;
		clk_in_ext = 1'b1;
		sync_pin_n = 1'b1;
		void'($urandom(32'hb35aab43));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		// reset values, the strobe register and an unmapped place
		for (int i = 0; i < 18; i++) rd_chk(regs[i], rst_val[i]);
		rd_chk(10'h192, 8'h00);
		// random shadow contents read back, then restored; no transfer yet
		for (int i = 0; i < 17; i++) begin
			v = 8'($urandom) & mask[i];
			// the host pairs force with nosync on single-stage controls and never sets vco with bypass
			if ((i == 1 || i == 3 || i == 5) && v[SS_FORCE])
				v[SS_NOSYNC] = 1'b1;
			if (i == 15 && v[IS_SEL_VCO])
				v[IS_BYP_DIV] = 1'b0;
			i_host.write_reg(regs[i], v);
			rd_chk(regs[i], v);
		end
		for (int i = 0; i < 17; i++) i_host.write_reg(regs[i], rst_val[i]);
		wait_n(4);
		check(chan_enable, 5'h1f);
		// distribution and input section power-downs take effect only on update
		i_host.write_reg(ADDR_SYSTEM, 8'h02);
		i_host.write_reg(ADDR_INPUT_SEL, 8'h1c);
		wait_n(3);
		check(chan_enable, 5'h1f);
		i_host.update();
		wait_n(3);
		check(chan_enable, 5'h00);
		check({input_powered, iface_powered, vco_powered}, 3'h0);
		rd_chk(ADDR_TRANSFER, 8'h00);
		i_host.write_reg(ADDR_SYSTEM, 8'h00);
		// ratios: channel 1 and channel 3 stage 1 alone, source divider bypassed or by two
		for (int k = 0; k < 4; k++) begin
			v[7:4] = 4'($urandom % 16);
			v[3:0] = 4'(2 * ($urandom % 7)) + {3'h0, v[4]};
			i_host.write_reg(ADDR_CH1_COUNTS, v);
			i_host.write_reg(ADDR_CH3_S1_COUNTS, v);
			i_host.write_reg(ADDR_CH3_CTRL, 8'h20);
			i_host.write_reg(ADDR_SRC_RATIO, 8'h00);
			i_host.write_reg(ADDR_INPUT_SEL, {7'h00, k[0] == 1'b0});
			i_host.update();
			measure(1, (v[7:4] + v[3:0] + 2) * (k[0] ? 2 : 1));
			measure(3, (v[7:4] + v[3:0] + 2) * (k[0] ? 2 : 1));
		end
		// static source codes stop the divided output of channel 1
		i_host.write_reg(ADDR_SRC_RATIO, {5'h00, SRC_STATIC_MIN});
		i_host.update();
		wait_n(10);
		lvl = chan_out[1];
		count_high(1, 60);
		check(16'(hits), lvl ? 16'd60 : 16'd0);
		// sync pin held with sync powered down, then working; forced channel ignores it
		i_host.write_reg(ADDR_SRC_RATIO, 8'h00);
		i_host.write_reg(ADDR_CH2_CTRL, 8'h20);
		i_host.write_reg(ADDR_SYSTEM, 8'h04);
		i_host.update();
		sync_pin_n <= 1'b0;
		measure(1, (v[7:4] + v[3:0] + 2) * 2);
		i_host.write_reg(ADDR_SYSTEM, 8'h00);
		i_host.update();
		wait_n(4);
		count_high(1, 40);
		check(16'(hits), 16'd0);
		count_high(2, 40);
		check(16'(hits), 16'd40);
		@(posedge clk);
		sync_pin_n <= 1'b1;
		measure(1, (v[7:4] + v[3:0] + 2) * 2);
		// soft sync bit holds the same as the pin
		i_host.write_reg(ADDR_SYSTEM, 8'h01);
		i_host.update();
		wait_n(4);
		count_high(1, 40);
		check(16'(hits), 16'd0);
		results();
	end
endmodule
